// File: dv/ebc_far_model.sv
// Far side model: external responder with acknowledge and a simple bus arbiter
`timescale 1ns/1ps
`default_nettype none
module ebc_far_model (
  // Clock
  input  wire logic       i_clk,
  // Device pins
  input  wire logic       i_rd_n,
  input  wire logic       i_rd_oe,
  input  wire logic       i_wr_n,
  input  wire logic       i_wr_oe,
  input  wire logic       i_req_n,
  input  wire logic       i_busy_n,
  input  wire logic       i_busy_oe,
  // Bench controls
  input  wire logic       i_release,
  input  wire logic       i_ack_force,
  input  wire logic [7:0] i_ack_delay,
  // Pins towards the device
  output logic            o_grant_n,
  output logic            o_busy_wire_n,
  output logic            o_ack_n
);
  logic [7:0] cnt;
  wire        active = (i_rd_oe & ~i_rd_n) | (i_wr_oe & ~i_wr_n);

  // Busy is released to the external pull-up when nobody drives it
  assign o_busy_wire_n = i_busy_oe ? i_busy_n : 1'b1;

  initial
  begin
    o_grant_n = 1'b1;
    o_ack_n   = 1'b1;
    cnt       = 8'h00;
  end

  // Acknowledge held off at cycle start, dropped once the strobe ends
  always @(posedge i_clk)
  begin
    cnt     <= active ? cnt + 8'h01 : 8'h00;
    o_ack_n <= ~(i_ack_force | (active & (cnt >= i_ack_delay)));
    if (i_release)
      o_grant_n <= 1'b1;
    else if (!i_req_n && o_busy_wire_n)
      o_grant_n <= 1'b0;
  end
endmodule : ebc_far_model
`default_nettype wire

// File: dv/external_bus_cycle_control_tb.sv
// Self-checking bench for the external bus cycle control block
`timescale 1ns/1ps
`default_nettype none
module external_bus_cycle_control_tb;
  logic       clk = 0, rst_n = 0, req = 0, wr = 0, hold = 0, lp = 0, rel = 0, fack = 0;
  logic       ssel = 0;
  logic [3:0] ws = 4'h0;
  logic [7:0] dly = 8'h00;
  logic [31:0] rnd;
  wire        gnt_n, busy_w, ack_n, done, busy_d, busy_oe, breq_n, mst;
  wire        rd_n, rd_oe, wr_n, wr_oe;
  integer     seed = 25, error_cnt = 0, comparisons = 0, i, lo;

  always #2.5 clk = ~clk;

  ebc_bus_ctrl DUT (.i_clk(clk), .i_arst_n(rst_n), .i_ext_req(req), .i_ext_wr(wr),
    .o_ext_done(done), .i_wait_states(ws), .i_ack_sync_select(ssel),
    .i_request_hold_bit(hold), .i_low_power(lp), .i_bus_grant_n(gnt_n),
    .i_bus_busy_n(busy_w), .o_bus_busy_n(busy_d), .o_bus_busy_oe(busy_oe),
    .o_bus_request_n(breq_n), .o_master(mst), .i_transfer_ack_n(ack_n),
    .o_read_strobe_n(rd_n), .o_read_strobe_oe(rd_oe), .o_write_strobe_n(wr_n),
    .o_write_strobe_oe(wr_oe));

  ebc_far_model u_far (.i_clk(clk), .i_rd_n(rd_n), .i_rd_oe(rd_oe), .i_wr_n(wr_n),
    .i_wr_oe(wr_oe), .i_req_n(breq_n), .i_busy_n(busy_d), .i_busy_oe(busy_oe),
    .i_release(rel), .i_ack_force(fack), .i_ack_delay(dly), .o_grant_n(gnt_n),
    .o_busy_wire_n(busy_w), .o_ack_n(ack_n));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Strobe-low cycles of one access: async ack needs two sync flops, the
  // agreeing-sample filter and one clock to finish after the responder acts
  function automatic int exp_len(input int n, input int d);
    if (n == 0)
      return 1;
    return (n + 1 > d + 5) ? n + 1 : d + 5;
  endfunction : exp_len

  task wrap_up;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // One access; counts strobe-low cycles and checks length bounds
  task access(input logic w, input logic [3:0] n, input logic [7:0] d);
    int   k;
    int   m;
    logic seen;
    @(negedge clk);
    req  = 1'b1;
    wr   = w;
    ws   = n;
    dly  = d;
    lo   = 0;
    seen = 1'b0;
    for (k = 0; k < 400 && !seen; k++)
    begin
      @(negedge clk);
      if (done === 1'b1)
        seen = 1'b1;
      if (rd_n === 1'b0 || wr_n === 1'b0)
      begin
        lo++;
        chk({rd_n, wr_n}, w ? 16'h0002 : 16'h0001);
        chk({busy_d, busy_oe, rd_oe, wr_oe}, 16'h0007);
      end
    end
    if (!seen)
    begin
      error_cnt++;
      wrap_up;
    end
    req = 1'b0;
    m   = (n > d) ? n : d;
    if (n == 0)
      chk(lo, 1);
    else
    begin
      chk(lo >= n, 1);
      chk(lo > d, 1);
      chk(lo <= m + 8, 1);
      chk(lo, exp_len(n, d));
    end
    cyc(1);
    chk(done, 0);
    cyc(3);
    // Request drops with no need left, mastership parks
    chk({breq_n, mst}, 16'h0003);
  endtask : access

  initial
  begin
    cyc(2);
    chk({breq_n, mst, rd_oe, wr_oe, busy_oe, done}, 16'h0020);
    rst_n = 1'b1;
    access(1'b0, 4'h0, 8'h0c);
    access(1'b1, 4'h1, 8'h00);
    access(1'b0, 4'hf, 8'h14);
    for (i = 0; i < 14; i++)
    begin
      rnd  = $random(seed);
      // Select bit must change nothing at this clock rate
      ssel = rnd[13];
      access(rnd[0], rnd[7:4], {3'h0, rnd[12:8]});
    end
    // Acknowledge with no access in flight must not finish anything
    fack = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      cyc(1);
      chk(done, 0);
    end
    fack = 1'b0;
    hold = 1'b1;
    cyc(3);
    chk(breq_n, 0);
    lp = 1'b1;
    cyc(3);
    chk(breq_n, 0);
    hold = 1'b0;
    cyc(3);
    chk(breq_n, 1);
    lp  = 1'b0;
    rel = 1'b1;
    cyc(8);
    chk({mst, rd_oe, wr_oe, busy_oe, busy_w}, 16'h0001);
    rel = 1'b0;
    req = 1'b1;
    cyc(6);
    rst_n = 1'b0;
    cyc(1);
    chk({breq_n, mst}, 16'h0002);
    chk({rd_oe, wr_oe, rd_n, wr_n, done}, 16'h0006);
    req   = 1'b0;
    rst_n = 1'b1;
    access(1'b1, 4'h2, 8'h03);
    wrap_up;
  end
endmodule : external_bus_cycle_control_tb
`default_nettype wire

// File: src/ebc_bus_ctrl.sv
// External bus cycle control: strobes, acknowledge stretching, bus request
`timescale 1ns/1ps
`default_nettype none
module ebc_bus_ctrl #(
  parameter int unsigned WS_W    = ebc_pkg::WS_W,
  parameter int unsigned CLK_MHZ = ebc_pkg::CLK_MHZ
) (
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_arst_n,
  // Core access request (external space only)
  input  wire logic            i_ext_req,
  input  wire logic            i_ext_wr,
  output logic                 o_ext_done,
  // Configuration
  input  wire logic [WS_W-1:0] i_wait_states,
  input  wire logic            i_ack_sync_select,
  input  wire logic            i_request_hold_bit,
  input  wire logic            i_low_power,
  // Arbitration pins
  input  wire logic            i_bus_grant_n,
  input  wire logic            i_bus_busy_n,
  output logic                 o_bus_busy_n,
  output logic                 o_bus_busy_oe,
  output logic                 o_bus_request_n,
  output logic                 o_master,
  // Acknowledge pin
  input  wire logic            i_transfer_ack_n,
  // Strobes
  output logic                 o_read_strobe_n,
  output logic                 o_read_strobe_oe,
  output logic                 o_write_strobe_n,
  output logic                 o_write_strobe_oe
);

  ebc_pkg::ebc_state_e state;
  ebc_pkg::ebc_state_e next_state;
  logic [WS_W-1:0]     wait_cnt;
  logic [WS_W-1:0]     next_wait_cnt;
  logic                is_write;
  logic                master;
  logic                next_master;
  logic                req;
  logic                next_req;
  logic                busy_release;
  logic [ebc_pkg::SYNC_PINS-1:0] pin_sync;
  logic                ack_filt_n;
  logic                zero_ws;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ebc_pin_in #(
    .WIDTH (ebc_pkg::SYNC_PINS)
  ) u_pin_in (
    .i_clk        (i_clk),
    .i_arst_n     (i_arst_n),
    .i_pin        ({i_bus_busy_n, i_bus_grant_n, i_transfer_ack_n}),
    .o_sync       (pin_sync),
    .o_ack_filt_n (ack_filt_n)
  );

  // ----------------------------------------------------------------
  // Acknowledge qualification
  // ----------------------------------------------------------------
  wire sync_allowed = (CLK_MHZ <= ebc_pkg::SYNC_ACK_MAX_MHZ);
  wire ack_sync_n   = pin_sync[ebc_pkg::PIN_ACK];
  wire ack_sel_n    = (i_ack_sync_select && sync_allowed) ? ack_sync_n
                                                          : ack_filt_n;
  wire ack_seen     = master && (state == ebc_pkg::EBC_ACCESS) && !ack_sel_n;
  wire grant_sync   = !pin_sync[ebc_pkg::PIN_GRANT];
  wire busy_free    = pin_sync[ebc_pkg::PIN_BUSY];

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  assign zero_ws      = (i_wait_states == ebc_pkg::WS_ZERO);
  wire   min_done     = (wait_cnt == ebc_pkg::WS_ZERO);
  // Programmed count is the floor; acknowledge only matters once it expires
  wire   cycle_end    = min_done && (zero_ws || ack_seen);
  wire   start_access = i_ext_req && master && !i_low_power;

  always_comb
  begin
    next_state    = state;
    next_wait_cnt = wait_cnt;
    unique case (state)
      ebc_pkg::EBC_IDLE:
      begin
        if (start_access)
        begin
          next_state    = ebc_pkg::EBC_ACCESS;
          next_wait_cnt = i_wait_states;
        end
      end
      ebc_pkg::EBC_ACCESS:
      begin
        if (!min_done)
          next_wait_cnt = wait_cnt - 1'b1;
        else if (cycle_end)
          next_state = ebc_pkg::EBC_FINISH;
      end
      ebc_pkg::EBC_FINISH:
        next_state = ebc_pkg::EBC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state    <= ebc_pkg::EBC_IDLE;
      wait_cnt <= ebc_pkg::WS_ZERO;
      is_write <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      wait_cnt <= next_wait_cnt;
      if (start_access && state == ebc_pkg::EBC_IDLE)
        is_write <= i_ext_wr;
    end
  end

  assign o_ext_done = (state == ebc_pkg::EBC_FINISH);

  // ----------------------------------------------------------------
  // Strobes: one direction per cycle, released when not master
  // ----------------------------------------------------------------
  wire next_is_write = (state == ebc_pkg::EBC_IDLE) ? i_ext_wr : is_write;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_read_strobe_n  <= 1'b1;
      o_write_strobe_n <= 1'b1;
    end
    else
    begin
      o_read_strobe_n  <= !(next_state == ebc_pkg::EBC_ACCESS && !next_is_write);
      o_write_strobe_n <= !(next_state == ebc_pkg::EBC_ACCESS &&  next_is_write);
    end
  end

  assign o_read_strobe_oe  = master;
  assign o_write_strobe_oe = master;

  // ----------------------------------------------------------------
  // Bus request and mastership
  // ----------------------------------------------------------------
  // Only external requests reach this block, so internal traffic never moves it
  wire need_bus = i_ext_req || (state != ebc_pkg::EBC_IDLE);
  assign next_req = i_low_power ? (i_request_hold_bit && req)
                                : (need_bus || i_request_hold_bit);
  wire take_bus = !master && req && grant_sync && busy_free;
  wire drop_bus = master && !grant_sync && (next_state == ebc_pkg::EBC_IDLE);
  assign next_master = take_bus ? 1'b1 : (drop_bus ? 1'b0 : master);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      req          <= 1'b0;
      master       <= 1'b0;
      busy_release <= 1'b0;
    end
    else
    begin
      req          <= next_req;
      master       <= next_master;
      busy_release <= drop_bus;
    end
  end

  assign o_bus_request_n = !req;
  assign o_master        = master;
  // Busy is driven low while master, then driven high once before release
  assign o_bus_busy_n    = !master;
  assign o_bus_busy_oe   = master || busy_release;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_access_start;
    state == ebc_pkg::EBC_IDLE && next_state == ebc_pkg::EBC_ACCESS;
  endsequence

  sequence s_strobe_low;
    !o_read_strobe_n || !o_write_strobe_n;
  endsequence

  strobe_exclusive_a : assert property (o_read_strobe_n || o_write_strobe_n)
    else $error("read and write strobes low together");
  strobe_master_a : assert property (s_strobe_low |-> o_read_strobe_oe && master)
    else $error("strobe asserted while not master");
  zero_wait_end_a : assert property (s_access_start ##0 zero_ws |=> ##1 o_ext_done)
    else $error("zero wait access not ended in fixed time");
  min_wait_hold_a : assert property (
    s_access_start ##0 (i_wait_states == 4'h2) |=> !o_ext_done [*3])
    else $error("access ended before programmed waits");
  ack_stretch_a : assert property (
    state == ebc_pkg::EBC_ACCESS && min_done && !zero_ws && ack_sel_n
    |=> state == ebc_pkg::EBC_ACCESS)
    else $error("access ended without acknowledge");
  ack_complete_a : assert property (
    state == ebc_pkg::EBC_ACCESS && min_done && ack_seen |=> o_ext_done)
    else $error("acknowledged access did not complete next clock");
  low_power_req_a : assert property (
    i_low_power && !i_request_hold_bit |=> o_bus_request_n)
    else $error("request not dropped in stop or wait");
  hold_keep_a : assert property (
    i_low_power && i_request_hold_bit |=> $stable(o_bus_request_n))
    else $error("request changed in stop or wait with hold");
  hold_request_a : assert property (
    !i_low_power && i_request_hold_bit |=> !o_bus_request_n)
    else $error("hold bit did not keep request asserted");
  take_after_busy_a : assert property ($rose(master) |-> $past(busy_free))
    else $error("mastership taken while bus busy");
  req_when_needed_a : assert property (
    i_ext_req && !i_low_power |=> !o_bus_request_n)
    else $error("bus request not raised for an external access");
  busy_pullup_a : assert property ($fell(master) |-> o_bus_busy_oe && o_bus_busy_n)
    else $error("busy not driven high on release");

endmodule : ebc_bus_ctrl
`default_nettype wire

// File: src/ebc_pin_in.sv
// Two-flop synchronisers for the arbitration and acknowledge pins
`timescale 1ns/1ps
`default_nettype none
module ebc_pin_in #(
  parameter int unsigned WIDTH = ebc_pkg::SYNC_PINS
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  // Raw pins
  input  wire logic [WIDTH-1:0] i_pin,
  // Synchronised levels
  output logic      [WIDTH-1:0] o_sync,
  // Acknowledge after one extra agreeing sample, for asynchronous mode
  output logic                  o_ack_filt_n
);

  logic [WIDTH-1:0] meta;
  logic             ack_prev;

  // ----------------------------------------------------------------
  // One synchroniser per pin
  // ----------------------------------------------------------------
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_sync
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        meta[g]   <= ebc_pkg::PIN_RESET[g];
        o_sync[g] <= ebc_pkg::PIN_RESET[g];
      end
      else
      begin
        meta[g]   <= i_pin[g];
        o_sync[g] <= meta[g];
      end
    end
  end

  // Async mode trades one cycle of latency for immunity to a lone stray sample
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ack_prev <= 1'b1;
    else
      ack_prev <= o_sync[ebc_pkg::PIN_ACK];
  end

  assign o_ack_filt_n = ack_prev | o_sync[ebc_pkg::PIN_ACK];

endmodule : ebc_pin_in
`default_nettype wire

// File: src/ebc_pkg.sv
// Shared constants for the external bus cycle control block
package ebc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WS_W        = 4;
  localparam int unsigned SYNC_PINS   = 3;

  // ----------------------------------------------------------------
  // Pin positions inside the synchroniser vector
  // ----------------------------------------------------------------
  localparam int unsigned PIN_ACK     = 0;
  localparam int unsigned PIN_GRANT   = 1;
  localparam int unsigned PIN_BUSY    = 2;

  // ----------------------------------------------------------------
  // Reset values (all active-low pins idle high)
  // ----------------------------------------------------------------
  localparam logic [SYNC_PINS-1:0] PIN_RESET = 3'h7;
  localparam logic [WS_W-1:0]      WS_ZERO   = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned CLK_MHZ        = 1000000 / CLK_PERIOD_PS;
  // Synchronous acknowledge is only legal at or below this rate
  localparam int unsigned SYNC_ACK_MAX_MHZ = 100;

  typedef enum logic [1:0] {
    EBC_IDLE,
    EBC_ACCESS,
    EBC_FINISH
  } ebc_state_e;

endpackage : ebc_pkg
